//--- afrml_fault_report.sv
/*
 * Fault-report control: hide bits, hold enables, misc control and the
 * analog fault clear, driving the combined alarm pin and the high-impedance
 * request for the power stage.
 * Assumes the fault detectors are asynchronous to sys_clk and that the
 * control-port slave issues single-cycle read and write strobes on sys_clk.
 */
`timescale 1ns/100ps
`include "afrml_map.svh"

module afrml_fault_report
	import afrml_pkg::*;
#(
	parameter int SYNC_STAGES = 2
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire afrml_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire afrml_faults_t fault_live_async,
	input wire logic clock_detect_async,
	output afrml_faults_t fault_status,
	output afrml_faults_t fault_report,
	output logic clock_detect_status,
	output logic alarm_n,
	output logic output_hiz
);

	// ****************************************
	// Parameter check
	// ****************************************
	generate
		if (SYNC_STAGES < 2) begin : g_bad_sync
			$error("SYNC_STAGES must be at least 2");
		end
	endgenerate

	// ****************************************
	// Input synchronisers
	// ****************************************
	// Detector outputs are asynchronous; only the last stage is read.
	localparam int SW = `AFRML_FV_WIDTH + 1;
	logic [SW-1:0] sync_r [SYNC_STAGES];
	logic [SW-1:0] sync_nxt [SYNC_STAGES];
	logic [`AFRML_FV_WIDTH-1:0] live;
	logic clk_det_live;

	always_comb begin
		sync_nxt[0] = {fault_live_async, clock_detect_async};
		for (int i = 1; i < SYNC_STAGES; i++) begin
			sync_nxt[i] = sync_r[i-1];
		end
	end

	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < SYNC_STAGES; i++) begin
			if (rst) begin
				sync_r[i] <= '0;
			end else begin
				sync_r[i] <= sync_nxt[i];
			end
		end
	end

	assign live = sync_r[SYNC_STAGES-1][SW-1:1];
	assign clk_det_live = sync_r[SYNC_STAGES-1][0];

	// ****************************************
	// Control registers
	// ****************************************
	logic [7:0] pin_hide_r;
	logic [7:0] pin_hide_nxt;
	logic [7:0] pin_latch_r;
	logic [7:0] pin_latch_nxt;
	logic [7:0] misc_r;
	logic [7:0] misc_nxt;
	logic [6:0] clear_rsvd_r;
	logic [6:0] clear_rsvd_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic clear_pulse;

	always_comb begin
		pin_hide_nxt = pin_hide_r;
		pin_latch_nxt = pin_latch_r;
		misc_nxt = misc_r;
		clear_rsvd_nxt = clear_rsvd_r;
		clear_pulse = 1'b0;
		if (reg_req.wr_en) begin
			unique case (reg_req.addr)
				`AFRML_OFS_PIN_HIDE: begin
					pin_hide_nxt = reg_req.wdata;
					// The reserved bit is read-only zero.
					pin_hide_nxt[`AFRML_BIT_PIN_HIDE_RSVD] = 1'b0;
				end
				`AFRML_OFS_PIN_LATCH: begin
					pin_latch_nxt = reg_req.wdata;
				end
				`AFRML_OFS_MISC: begin
					misc_nxt = reg_req.wdata;
				end
				`AFRML_OFS_FAULT_CLEAR: begin
					clear_rsvd_nxt = reg_req.wdata[6:0];
					clear_pulse = reg_req.wdata[`AFRML_BIT_ANALOG_CLEAR];
				end
				default: begin
				end
			endcase
		end
		rdata_nxt = rdata_r;
		if (reg_req.rd_en) begin
			unique case (reg_req.addr)
				`AFRML_OFS_PIN_HIDE: rdata_nxt = pin_hide_r;
				`AFRML_OFS_PIN_LATCH: rdata_nxt = pin_latch_r;
				`AFRML_OFS_MISC: rdata_nxt = misc_r;
				`AFRML_OFS_FAULT_CLEAR: rdata_nxt = {1'b0, clear_rsvd_r};
				default: rdata_nxt = `AFRML_RST_NONE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_hide_r <= `AFRML_RST_PIN_HIDE;
			pin_latch_r <= `AFRML_RST_PIN_LATCH;
			misc_r <= `AFRML_RST_MISC;
			clear_rsvd_r <= 7'h00;
			rdata_r <= `AFRML_RST_NONE;
		end else begin
			pin_hide_r <= pin_hide_nxt;
			pin_latch_r <= pin_latch_nxt;
			misc_r <= misc_nxt;
			clear_rsvd_r <= clear_rsvd_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ****************************************
	// Hide and hold vectors
	// ****************************************
	logic [`AFRML_FV_WIDTH-1:0] hide;
	logic [`AFRML_FV_WIDTH-1:0] hold;

	always_comb begin
		hide = '0;
		hide[`AFRML_FV_OVERTEMP_SHUTDOWN] = pin_hide_r[`AFRML_BIT_OVERTEMP_SHUTDOWN_HIDE];
		hide[`AFRML_FV_CORE_UV] = pin_hide_r[`AFRML_BIT_CORE_UV_HIDE];
		hide[`AFRML_FV_CORE_OV] = pin_hide_r[`AFRML_BIT_CORE_OV_HIDE];
		hide[`AFRML_FV_CLK] = pin_hide_r[`AFRML_BIT_CLK_HIDE];
		// One bit hides both directions of the power-stage supply fault.
		hide[`AFRML_FV_PSUP_UV] = pin_hide_r[`AFRML_BIT_PSUP_HIDE];
		hide[`AFRML_FV_PSUP_OV] = pin_hide_r[`AFRML_BIT_PSUP_HIDE];
		hide[`AFRML_FV_DC] = pin_hide_r[`AFRML_BIT_DC_HIDE];
		hide[`AFRML_FV_OC] = pin_hide_r[`AFRML_BIT_OC_HIDE];
		hide[`AFRML_FV_OTW] = pin_latch_r[`AFRML_BIT_OTW_HIDE];
		hide[`AFRML_FV_CL_WARN] = pin_latch_r[`AFRML_BIT_CL_WARN_HIDE];
		hide[`AFRML_FV_CL_ERR] = pin_latch_r[`AFRML_BIT_CL_ERR_HIDE];

		// Supply, DC and overcurrent faults are always held analog faults.
		hold = '1;
		hold[`AFRML_FV_CL_ERR] = pin_latch_r[`AFRML_BIT_CL_ERR_HOLD];
		hold[`AFRML_FV_CL_WARN] = pin_latch_r[`AFRML_BIT_CL_WARN_HOLD];
		hold[`AFRML_FV_CLK] = pin_latch_r[`AFRML_BIT_CLK_HOLD];
		hold[`AFRML_FV_OVERTEMP_SHUTDOWN] = pin_latch_r[`AFRML_BIT_OVERTEMP_SHUTDOWN_HOLD];
		hold[`AFRML_FV_OTW] = pin_latch_r[`AFRML_BIT_OTW_HOLD];
	end

	// ****************************************
	// Status, report, alarm and high impedance
	// ****************************************
	logic [`AFRML_FV_WIDTH-1:0] status_r;
	logic [`AFRML_FV_WIDTH-1:0] status_nxt;
	logic [`AFRML_FV_WIDTH-1:0] report_r;
	logic [`AFRML_FV_WIDTH-1:0] report_nxt;
	logic [`AFRML_FV_WIDTH-1:0] hiz_src;
	logic clk_det_r;
	logic clk_det_nxt;
	logic alarm_n_r;
	logic alarm_n_nxt;
	logic hiz_r;
	logic hiz_nxt;

	always_comb begin
		// A live condition wins over a clear in the same cycle.
		status_nxt = live | (status_r & {`AFRML_FV_WIDTH{~clear_pulse}});
		report_nxt = live | (report_r & hold & {`AFRML_FV_WIDTH{~clear_pulse}});
		if (misc_r[`AFRML_BIT_CLK_DET_HOLD]) begin
			clk_det_nxt = clk_det_live | (clk_det_r & ~clear_pulse);
		end else begin
			clk_det_nxt = clk_det_live;
		end
		alarm_n_nxt = ~|(report_nxt & ~hide);
		hiz_src = report_nxt;
		// Auto-recovery lets the stage come back once the die cools.
		if (misc_r[`AFRML_BIT_OVERTEMP_SHUTDOWN_AUTO_REC]) begin
			hiz_src[`AFRML_FV_OVERTEMP_SHUTDOWN] = live[`AFRML_FV_OVERTEMP_SHUTDOWN];
		end
		hiz_nxt = |(hiz_src & `AFRML_HIZ_CLASS);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			status_r <= '0;
			report_r <= '0;
			clk_det_r <= 1'b0;
			alarm_n_r <= 1'b1;
			hiz_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			report_r <= report_nxt;
			clk_det_r <= clk_det_nxt;
			alarm_n_r <= alarm_n_nxt;
			hiz_r <= hiz_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign fault_status = afrml_faults_t'(status_r);
	assign fault_report = afrml_faults_t'(report_r);
	assign clock_detect_status = clk_det_r;
	assign alarm_n = alarm_n_r;
	assign output_hiz = hiz_r;

endmodule

//--- afrml_map.svh
/*
 * Register offsets, reset values, field positions and fault vector indices
 * for the amplifier fault-report mask and latch block.
 * Assumes it is included by its bare name after the package is compiled.
 */
`ifndef AFRML_MAP_SVH
`define AFRML_MAP_SVH

// ****************************************
// Register offsets on the control port
// ****************************************
`define AFRML_OFS_PIN_HIDE 8'h74
`define AFRML_OFS_PIN_LATCH 8'h75
`define AFRML_OFS_MISC 8'h76
`define AFRML_OFS_FAULT_CLEAR 8'h78

// ****************************************
// Reset values
// ****************************************
`define AFRML_RST_PIN_HIDE 8'h00
`define AFRML_RST_PIN_LATCH 8'hf8
`define AFRML_RST_MISC 8'h00
`define AFRML_RST_FAULT_CLEAR 8'h00
`define AFRML_RST_NONE 8'h00

// ****************************************
// Field positions, first pin-control register
// ****************************************
`define AFRML_BIT_OVERTEMP_SHUTDOWN_HIDE 7
`define AFRML_BIT_CORE_UV_HIDE 6
`define AFRML_BIT_CORE_OV_HIDE 5
`define AFRML_BIT_CLK_HIDE 4
`define AFRML_BIT_PIN_HIDE_RSVD 3
`define AFRML_BIT_PSUP_HIDE 2
`define AFRML_BIT_DC_HIDE 1
`define AFRML_BIT_OC_HIDE 0

// ****************************************
// Field positions, second pin-control register
// ****************************************
`define AFRML_BIT_CL_ERR_HOLD 7
`define AFRML_BIT_CL_WARN_HOLD 6
`define AFRML_BIT_CLK_HOLD 5
`define AFRML_BIT_OVERTEMP_SHUTDOWN_HOLD 4
`define AFRML_BIT_OTW_HOLD 3
`define AFRML_BIT_OTW_HIDE 2
`define AFRML_BIT_CL_WARN_HIDE 1
`define AFRML_BIT_CL_ERR_HIDE 0

// ****************************************
// Field positions, misc and clear registers
// ****************************************
`define AFRML_BIT_CLK_DET_HOLD 7
`define AFRML_BIT_OVERTEMP_SHUTDOWN_AUTO_REC 4
`define AFRML_BIT_ANALOG_CLEAR 7

// ****************************************
// Fault vector indices (match the packed struct order)
// ****************************************
`define AFRML_FV_OVERTEMP_SHUTDOWN 10
`define AFRML_FV_CORE_UV 9
`define AFRML_FV_CORE_OV 8
`define AFRML_FV_CLK 7
`define AFRML_FV_PSUP_UV 6
`define AFRML_FV_PSUP_OV 5
`define AFRML_FV_DC 4
`define AFRML_FV_OC 3
`define AFRML_FV_CL_ERR 2
`define AFRML_FV_CL_WARN 1
`define AFRML_FV_OTW 0
`define AFRML_FV_WIDTH 11

// Faults (not warnings) that force the power stage to high impedance.
`define AFRML_HIZ_CLASS 11'h7fc

`endif

//--- afrml_pkg.sv
/*
 * Types for the amplifier fault-report mask and latch block.
 * Assumes afrml_map.svh gives the matching bit indices.
 */
package afrml_pkg;

	// One bit per protection event, most significant first.
	typedef struct packed {
		logic overtemp_shutdown;
		logic core_supply_under;
		logic core_supply_over;
		logic clock_error;
		logic power_stage_supply_under;
		logic power_stage_supply_over;
		logic dc_error;
		logic overcurrent;
		logic current_limit_error;
		logic current_limit_warn;
		logic overtemp_warning;
	} afrml_faults_t;

	// Register access request from the device's control-port slave.
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} afrml_reg_req_t;

endpackage

//--- afrml_fault_report_properties.sv
/* Port assertions for the fault-report block.
   Assumes a bind from the testbench and the default two-flop synchroniser. */
`timescale 1ns/100ps
`include "afrml_map.svh"
module afrml_fault_report_properties
	import afrml_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire afrml_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire afrml_faults_t fault_live_async,
	input wire logic clock_detect_async,
	input wire afrml_faults_t fault_status,
	input wire afrml_faults_t fault_report,
	input wire logic clock_detect_status,
	input wire logic alarm_n,
	input wire logic output_hiz
);
	wire logic clr_w = reg_req.wr_en && reg_req.addr == 8'h78 && reg_req.wdata[7];
	wire logic rd_bad = reg_req.rd_en && (reg_req.addr < 8'h74 || reg_req.addr > 8'h78);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Three quiet samples leave both synchroniser flops empty.
	sequence quiet_s; (fault_live_async == '0)[*3]; endsequence
	sequence clear_s; quiet_s ##0 clr_w; endsequence
	clear_empties_a: assert property (clear_s |=> fault_status == '0 && fault_report == '0)
		else $error("clear left status or report set");
	alarm_cause_a: assert property (!alarm_n |-> fault_report != '0)
		else $error("alarm low without a report");
	status_set_a: assert property ($rose(fault_live_async.overcurrent) |-> ##3 fault_status.overcurrent)
		else $error("status not set by fault");
	status_sticky_a: assert property (!clr_w |=> (fault_status | ~$past(fault_status)) == '1)
		else $error("status fell without clear");
	hiz_cause_a: assert property (output_hiz |-> (fault_report & `AFRML_HIZ_CLASS) != '0)
		else $error("hiz without a fault report");
	unmapped_zero_a: assert property (rd_bad |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	clear_bit_zero_a: assert property (reg_req.rd_en && reg_req.addr == 8'h78 |=> !reg_rdata[7])
		else $error("clear bit read back");
	detect_rise_a: assert property ($rose(clock_detect_async) |-> ##3 clock_detect_status)
		else $error("clock detect not seen");
endmodule

//--- afrml_fault_src.sv
/* Fault detector model feeding the block's raw inputs.
   Assumes the bench requests levels on sys_clk edges. */
`timescale 1ns/100ps
module afrml_fault_src
	import afrml_pkg::*;
(
	input wire logic sys_clk,
	input wire afrml_faults_t want,
	input wire logic want_det,
	output afrml_faults_t fault_live_async = '0,
	output logic clock_detect_async = 1'b0
);
	// Real detectors are not tied to sys_clk, so levels move well off the edge.
	always @(posedge sys_clk) begin
		fault_live_async <= #13 want;
		clock_detect_async <= #13 want_det;
	end
endmodule

//--- afrml_fault_report_test.sv
/* Self-checking bench for the fault-report block.
   Assumes three-edge fault latency and one-cycle register reads. */
`timescale 1ns/100ps
`include "afrml_map.svh"
module afrml_fault_report_test;
	import afrml_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	afrml_reg_req_t reg_req = '0;
	afrml_faults_t want = '0;
	logic want_det = 1'b0;
	logic [7:0] reg_rdata;
	afrml_faults_t fault_live_async, fault_status, fault_report;
	logic clock_detect_async, clock_detect_status, alarm_n, output_hiz;
	int error_cnt = 0;
	int total_checks = 0;
	always #20 sys_clk = ~sys_clk;
	afrml_fault_src src (.sys_clk(sys_clk), .want(want), .want_det(want_det),
		.fault_live_async(fault_live_async), .clock_detect_async(clock_detect_async));
	afrml_fault_report dut (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.fault_live_async(fault_live_async), .clock_detect_async(clock_detect_async),
		.fault_status(fault_status), .fault_report(fault_report),
		.clock_detect_status(clock_detect_status), .alarm_n(alarm_n), .output_hiz(output_hiz));
	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk) reg_req <= '0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge sys_clk) reg_req <= '0;
		#1 chk("reg_rdata", {3'b000, exp}, {3'b000, reg_rdata});
	endtask
	task automatic pulse(input int i);
		@(posedge sys_clk) want <= afrml_faults_t'(11'h001 << i);
		tick(5);
		@(posedge sys_clk) want <= '0;
		tick(5);
	endtask
	task automatic t_regs();
		rdchk(8'h74, 8'h00);
		rdchk(8'h75, 8'hf8);
		rdchk(8'h76, 8'h00);
		rdchk(8'h70, 8'h00);
		wr(8'h74, 8'hff);
		rdchk(8'h74, 8'hf7);
		wr(8'h76, 8'h6f);
		rdchk(8'h76, 8'h6f);
		wr(8'h75, 8'h00);
		rdchk(8'h75, 8'h00);
		wr(8'h78, 8'h80);
		rdchk(8'h78, 8'h00);
		wr(8'h74, 8'h00);
		wr(8'h75, 8'hf8);
		wr(8'h76, 8'h00);
	endtask
	task automatic t_hide();
		logic [7:0] hreg [11] = '{8'h75, 8'h75, 8'h75, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74};
		int hbit [11] = '{2, 1, 0, 0, 1, 2, 2, 4, 5, 6, 7};
		for (int i = 0; i < 11; i++) begin
			logic [7:0] base;
			base = (hreg[i] == 8'h75) ? 8'hf8 : 8'h00;
			@(posedge sys_clk) want <= afrml_faults_t'(11'h001 << i);
			tick(5);
			chk("alarm_n", 11'h000, alarm_n);
			chk("output_hiz", `AFRML_HIZ_CLASS >> i & 11'h001, output_hiz);
			wr(hreg[i], base | (8'h01 << hbit[i]));
			tick(3);
			chk("alarm_n", 11'h001, alarm_n);
			chk("fault_status", 11'h001 << i, fault_status);
			@(posedge sys_clk) want <= '0;
			tick(5);
			wr(8'h78, 8'h80);
			wr(hreg[i], base);
			tick(3);
			chk("fault_report", 11'h000, fault_report);
		end
	endtask
	task automatic t_hold();
		int idx [5] = '{2, 1, 7, 10, 0};
		for (int j = 0; j < 5; j++) begin
			for (int h = 0; h < 2; h++) begin
				wr(8'h75, h ? 8'h80 >> j : 8'h00);
				pulse(idx[j]);
				chk("fault_report", h ? 11'h001 << idx[j] : 11'h000, fault_report);
				chk("alarm_n", h ? 11'h000 : 11'h001, alarm_n);
				wr(8'h78, 8'h80);
				tick(3);
			end
		end
		wr(8'h75, 8'hf8);
	endtask
	task automatic t_misc();
		for (int m = 0; m < 2; m++) begin
			wr(8'h76, m ? 8'h90 : 8'h00);
			@(posedge sys_clk) want_det <= 1'b1;
			pulse(10);
			@(posedge sys_clk) want_det <= 1'b0;
			tick(5);
			chk("output_hiz", m ? 11'h000 : 11'h001, output_hiz);
			chk("clock_detect_status", 11'(m), clock_detect_status);
			wr(8'h78, 8'h80);
			tick(3);
			chk("clock_detect_status", 11'h000, clock_detect_status);
		end
		wr(8'h76, 8'h00);
	endtask
	task automatic wrap_up();
		if (error_cnt == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs();
		t_hide();
		t_hold();
		t_misc();
		wrap_up();
	end
	// The tests need about 540 cycles, so five thousand means a hang.
	initial begin
		#200000;
		error_cnt++;
		wrap_up();
	end
endmodule
bind afrml_fault_report afrml_fault_report_properties props (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .fault_live_async(fault_live_async), .clock_detect_async(clock_detect_async),
	.fault_status(fault_status), .fault_report(fault_report), .clock_detect_status(clock_detect_status),
	.alarm_n(alarm_n), .output_hiz(output_hiz));
